// ==== rtl/sdrlat_pkg.sv ====
// constants and types for the single-data-rate read latency lookup
package sdrlat_pkg;

    // latency codes and the serial clock band each one serves
    localparam logic [1:0] LC_50  = 2'h3;  // up to 50 MHz
    localparam logic [1:0] LC_80  = 2'h0;  // up to 80 MHz
    localparam logic [1:0] LC_90  = 2'h1;  // up to 90 MHz
    localparam logic [1:0] LC_104 = 2'h2;  // up to 104 MHz, or 133 MHz band

    // cycle counts; ffh marks a command barred at that band
    localparam logic [7:0] CYC_NONE = 8'hff;
    localparam logic [7:0] CYC_0    = 8'h00;
    localparam logic [7:0] CYC_1    = 8'h01;
    localparam logic [7:0] CYC_2    = 8'h02;
    localparam logic [7:0] CYC_4    = 8'h04;
    localparam logic [7:0] CYC_5    = 8'h05;
    localparam logic [7:0] CYC_6    = 8'h06;
    localparam logic [7:0] CYC_8    = 8'h08;

    // read opcodes, 3-byte and 4-byte address forms
    localparam logic [7:0] OP_RD3  = 8'h03;
    localparam logic [7:0] OP_RD4  = 8'h13;
    localparam logic [7:0] OP_FR3  = 8'h0b;
    localparam logic [7:0] OP_FR4  = 8'h0c;
    localparam logic [7:0] OP_DO3  = 8'h3b;
    localparam logic [7:0] OP_DO4  = 8'h3c;
    localparam logic [7:0] OP_QO3  = 8'h6b;
    localparam logic [7:0] OP_QO4  = 8'h6c;
    localparam logic [7:0] OP_DIO3 = 8'hbb;
    localparam logic [7:0] OP_DIO4 = 8'hbc;
    localparam logic [7:0] OP_QIO3 = 8'heb;
    localparam logic [7:0] OP_QIO4 = 8'hec;

    // query parameter layout
    localparam logic [7:0] QT_PARAM_ID = 8'h90;
    localparam logic [7:0] QT_LEN      = 8'h56;
    localparam logic [7:0] QT_ROWS     = 8'h06;
    localparam logic [7:0] QT_ROW_LEN  = 8'h0e;
    localparam logic [7:0] QT_HDR_F    = 8'h46;
    localparam logic [7:0] QT_HDR_C    = 8'h43;
    localparam logic [7:0] QT_F50      = 8'h32;
    localparam logic [7:0] QT_F80      = 8'h50;
    localparam logic [7:0] QT_F90      = 8'h5a;
    localparam logic [7:0] QT_F104     = 8'h68;
    localparam logic [7:0] QT_F133     = 8'h85;
    localparam logic [6:0] QT_OFS_ID   = 7'h00;
    localparam logic [6:0] QT_OFS_LEN  = 7'h01;
    localparam logic [6:0] QT_OFS_ROWS = 7'h02;
    localparam logic [6:0] QT_OFS_RLEN = 7'h03;
    localparam logic [6:0] QT_OFS_ROW0 = 7'h04;
    localparam logic [6:0] QT_OFS_LAST = 7'h57;
    localparam int         QT_ROW_BYTES = 14;

    // read command classes
    typedef enum logic [2:0] {
        CMD_READ, CMD_FAST, CMD_DOUT, CMD_QOUT, CMD_DIO, CMD_QIO, CMD_NONE
    } sdrlat_cmd_e;

    // mode and latency pair
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] lat;
    } sdrlat_cyc_s;

    // lookup answer
    typedef struct packed {
        logic        valid;
        logic        unsup;
        sdrlat_cmd_e cmd;
        sdrlat_cyc_s cyc;
    } sdrlat_res_s;

endpackage : sdrlat_pkg

// ==== rtl/sdrlat_lookup.sv ====
// read latency lookup: link-side opcode capture, crossing, table and query bytes
// Operation
// - code 11b serves clocks up to 50 MHz
// - code 11b: plain/fast/dual/quad out zero cycles
// - code 11b dual I/O: 4 latency
// - code 11b quad I/O: 2 mode, 1 latency
// - code 00b to 80 MHz: DIO 4, QIO 2+4
// - codes 00b-10b: fast/out reads 8 latency
// - plain read barred above 50 MHz, FFh
// - code 01b to 90 MHz: DIO 5, QIO 2+4
// - code 10b to 104 MHz: DIO 6, QIO 2+5
// - 133 MHz band: only fast read, 8
// - quad I/O has 2 mode cycles in every band but 133 MHz
// - query parameter 90h, 14-byte rows
`timescale 1ns/10ps
module sdrlat_lookup
    import sdrlat_pkg::*;
(
    // system clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    // link side, serial clock domain
    input  wire logic        clk_link_in,
    input  wire logic        cmd_strobe_in,
    input  wire logic [7:0]  cmd_opcode_in,
    // configuration, system domain
    input  wire logic [1:0]  latency_code_in,
    input  wire logic        band_133_in,
    // query table access
    input  wire logic [6:0]  query_offset_in,
    output logic      [7:0]  query_byte_out,
    // lookup answer
    output sdrlat_res_s      result_out
);

    // opcode to command class
    function automatic sdrlat_cmd_e op_class(input logic [7:0] op);
        case (op)
            OP_RD3, OP_RD4:   op_class = CMD_READ;
            OP_FR3, OP_FR4:   op_class = CMD_FAST;
            OP_DO3, OP_DO4:   op_class = CMD_DOUT;
            OP_QO3, OP_QO4:   op_class = CMD_QOUT;
            OP_DIO3, OP_DIO4: op_class = CMD_DIO;
            OP_QIO3, OP_QIO4: op_class = CMD_QIO;
            default:          op_class = CMD_NONE;
        endcase
    endfunction : op_class

    // mode and latency for a class, latency code and band
    function automatic sdrlat_cyc_s cyc_of(input sdrlat_cmd_e c, input logic [1:0] lc,
                                           input logic b133);
        sdrlat_cyc_s r;
        r = '{mode: CYC_NONE, lat: CYC_NONE};
        if (lc == LC_50)
        begin
            case (c)
                CMD_READ, CMD_FAST, CMD_DOUT, CMD_QOUT: r = '{mode: CYC_0, lat: CYC_0};
                CMD_DIO: r = '{mode: CYC_0, lat: CYC_4};
                // quad I/O 2 mode 1 latency
                CMD_QIO: r = '{mode: CYC_2, lat: CYC_1};
                default: r = '{mode: CYC_NONE, lat: CYC_NONE};
            endcase
        end
        // 133 MHz band allows fast read only
        else if (lc == LC_104 && b133)
        begin
            if (c == CMD_FAST)
                r = '{mode: CYC_0, lat: CYC_8};
        end
        else
        begin
            case (c)
                CMD_READ: r = '{mode: CYC_NONE, lat: CYC_NONE};
                // fast and output reads 8 latency
                CMD_FAST, CMD_DOUT, CMD_QOUT: r = '{mode: CYC_0, lat: CYC_8};
                CMD_DIO: r = '{mode: CYC_0,
                               lat: (lc == LC_80) ? CYC_4 : (lc == LC_90) ? CYC_5 : CYC_6};
                CMD_QIO: r = '{mode: CYC_2, lat: (lc == LC_104) ? CYC_5 : CYC_4};
                default: r = '{mode: CYC_NONE, lat: CYC_NONE};
            endcase
        end
        cyc_of = r;
    endfunction : cyc_of

    // one byte of the query parameter
    function automatic logic [7:0] qt_byte(input logic [6:0] ofs);
        int          rel;
        int          row;
        int          col;
        logic [7:0]  b;
        sdrlat_cyc_s cy;
        rel = int'(ofs) - int'(QT_OFS_ROW0);
        row = rel / QT_ROW_BYTES;
        col = rel % QT_ROW_BYTES;
        b   = CYC_NONE;
        cy  = '{mode: CYC_NONE, lat: CYC_NONE};
        case (ofs)
            QT_OFS_ID:   b = QT_PARAM_ID;
            QT_OFS_LEN:  b = QT_LEN;
            QT_OFS_ROWS: b = QT_ROWS;
            QT_OFS_RLEN: b = QT_ROW_LEN;
            default:
            begin
                if (ofs > QT_OFS_LAST)
                    b = CYC_NONE;
                else if (row == 0)
                begin
                    // header row: column tags then opcodes
                    case (col)
                        0:       b = QT_HDR_F;
                        1:       b = QT_HDR_C;
                        2:       b = OP_RD3;
                        3:       b = OP_RD4;
                        4:       b = OP_FR3;
                        5:       b = OP_FR4;
                        6:       b = OP_DO3;
                        7:       b = OP_DO4;
                        8:       b = OP_QO3;
                        9:       b = OP_QO4;
                        10:      b = OP_DIO3;
                        11:      b = OP_DIO4;
                        12:      b = OP_QIO3;
                        default: b = OP_QIO4;
                    endcase
                end
                else
                begin
                    // data rows: frequency, code, then mode/latency pairs
                    case (row)
                        1:       cy = cyc_of(sdrlat_cmd_e'(3'((col - 2) / 2)), LC_50, 1'b0);
                        2:       cy = cyc_of(sdrlat_cmd_e'(3'((col - 2) / 2)), LC_80, 1'b0);
                        3:       cy = cyc_of(sdrlat_cmd_e'(3'((col - 2) / 2)), LC_90, 1'b0);
                        4:       cy = cyc_of(sdrlat_cmd_e'(3'((col - 2) / 2)), LC_104, 1'b0);
                        default: cy = cyc_of(sdrlat_cmd_e'(3'((col - 2) / 2)), LC_104, 1'b1);
                    endcase
                    if (col == 0)
                        b = (row == 1) ? QT_F50 : (row == 2) ? QT_F80 : (row == 3) ? QT_F90 :
                            (row == 4) ? QT_F104 : QT_F133;
                    else if (col == 1)
                        b = {6'h00, (row == 1) ? LC_50 : (row == 2) ? LC_80 :
                                    (row == 3) ? LC_90 : LC_104};
                    else
                        b = col[0] ? cy.lat : cy.mode;
                end
            end
        endcase
        qt_byte = b;
    endfunction : qt_byte

    // link domain state
    typedef struct packed {
        logic [7:0] opcode;  // held until next command
        logic       toggle;  // flips once per command
    } sdrlat_link_s;

    // system domain state
    typedef struct packed {
        logic [2:0]  sync;   // toggle synchroniser
        logic        seen;   // last accepted toggle level
        logic [7:0]  qbyte;  // query byte register
        sdrlat_res_s res;    // lookup answer
    } sdrlat_sys_s;

    sdrlat_link_s link_q;       // link registers
    sdrlat_link_s next_link_q;  // link next value
    sdrlat_sys_s  sys_q;        // system registers
    sdrlat_sys_s  next_sys_q;   // system next value
    logic         cmd_event;    // accepted command this cycle

    // link side: capture opcode, flip toggle
    always_comb
    begin
        next_link_q = link_q;
        if (cmd_strobe_in)
        begin
            next_link_q.opcode = cmd_opcode_in;
            next_link_q.toggle = ~link_q.toggle;
        end
    end

    // link registers
    always_ff @(posedge clk_link_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            link_q <= '0;
        else
            link_q <= next_link_q;
    end

    // event once stages two and three agree on a new level
    assign cmd_event = (sys_q.sync[1] == sys_q.sync[2]) && (sys_q.sync[2] != sys_q.seen);

    // system side: crossing, lookup, query bytes
    always_comb
    begin
        next_sys_q           = sys_q;
        next_sys_q.sync      = {sys_q.sync[1:0], link_q.toggle};
        next_sys_q.qbyte     = qt_byte(query_offset_in);
        next_sys_q.res.valid = 1'b0;
        if (cmd_event)
        begin
            // opcode has been still since the toggle flipped
            next_sys_q.seen      = sys_q.sync[2];
            next_sys_q.res.valid = 1'b1;
            next_sys_q.res.cmd   = op_class(link_q.opcode);
            next_sys_q.res.cyc   = cyc_of(op_class(link_q.opcode), latency_code_in,
                                          band_133_in);
            next_sys_q.res.unsup = (next_sys_q.res.cyc.lat == CYC_NONE);
        end
    end

    // system registers
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sys_q <= '{sync: '0, seen: 1'b0, qbyte: '0,
                       res: '{valid: 1'b0, unsup: 1'b0, cmd: CMD_NONE, cyc: '0}};
        else
            sys_q <= next_sys_q;
    end

    assign query_byte_out = sys_q.qbyte;
    assign result_out     = sys_q.res;

    // answer one cycle after acceptance
    a_answer_follows_event: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cmd_event |=> result_out.valid)
        else $error("answer missing after command");

    a_band50_zero_cycles: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cmd_event && latency_code_in == LC_50 && op_class(link_q.opcode) inside
        {CMD_READ, CMD_FAST, CMD_DOUT, CMD_QOUT} |=> result_out.cyc == '0)
        else $error("50 MHz band read not zero cycles");

    a_band50_quad_io: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cmd_event && latency_code_in == LC_50 && op_class(link_q.opcode) == CMD_QIO
        |=> result_out.cyc.mode == CYC_2 && result_out.cyc.lat == CYC_1)
        else $error("50 MHz quad I/O cycles wrong");

    a_quad_io_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        result_out.valid && result_out.cmd == CMD_QIO && !result_out.unsup
        |-> result_out.cyc.mode == CYC_2)
        else $error("quad I/O mode cycles not two");

    a_read_barred: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        result_out.valid && result_out.cmd == CMD_READ && $past(latency_code_in) != LC_50
        |-> result_out.unsup && result_out.cyc.mode == CYC_NONE)
        else $error("plain read not barred above 50 MHz");

    a_fast_eight: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        result_out.valid && result_out.cmd == CMD_FAST && $past(latency_code_in) != LC_50
        |-> result_out.cyc.lat == CYC_8)
        else $error("fast read latency not eight");

    a_dual_io_lat: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cmd_event && latency_code_in == LC_90 && op_class(link_q.opcode) == CMD_DIO
        |=> result_out.cyc.lat == CYC_5)
        else $error("90 MHz dual I/O latency not five");

    a_band133_only: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        cmd_event && latency_code_in == LC_104 && band_133_in
        && op_class(link_q.opcode) != CMD_FAST |=> result_out.unsup)
        else $error("133 MHz band allowed non-fast read");

    a_query_header: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        query_offset_in == QT_OFS_ID ##1 query_offset_in == QT_OFS_RLEN
        |-> query_byte_out == QT_PARAM_ID ##1 query_byte_out == QT_ROW_LEN)
        else $error("query header bytes wrong");

endmodule : sdrlat_lookup

// ==== sim/sdrlat_host_model.sv ====
// host-side model: issues read opcodes on a gated link clock
`timescale 1ns/10ps
module sdrlat_host_model
    import sdrlat_pkg::*;
(
    // link side toward the lookup
    output logic       clk_link_out,
    output logic       cmd_strobe_out,
    output logic [7:0] cmd_opcode_out
);
    // idle: clock low, no strobe
    initial
    begin
        clk_link_out   = 1'b0;
        cmd_strobe_out = 1'b0;
        cmd_opcode_out = 8'ha5;
    end
    // one link cycle per call; the clock stands still between calls
    // host drives the given strobe level and opcode
    task automatic frame(input logic stb, input logic [7:0] op);
        #1.3;
        cmd_strobe_out = stb;
        cmd_opcode_out = op;
        #3;
        clk_link_out = 1'b1;
        #3;
        clk_link_out = 1'b0;
        // released opcode shows garbage, not the old value
        cmd_strobe_out = 1'b0;
        cmd_opcode_out = ~op;
    endtask : frame
endmodule : sdrlat_host_model

// ==== sim/sdrlat_lookup_tb.sv ====
// self-checking bench for the read latency lookup
`timescale 1ns/10ps
module sdrlat_lookup_tb;
    import sdrlat_pkg::*;
    // clocks, reset and stimulus
    logic        clk_sys_in;
    logic        rst_b_in;
    logic        clk_link;
    logic        cmd_strobe;
    logic [7:0]  cmd_opcode;
    logic [1:0]  latency_code_in;
    logic        band_133_in;
    logic [6:0]  query_offset_in;
    logic [7:0]  query_byte_out;
    sdrlat_res_s result_out;
    int          miscompares = 0;
    int          num_checks  = 0;
    // band rows: code, 133 select, frequency byte
    logic [1:0]  row_code [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2};
    logic        row_b133 [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0]  row_freq [5] = '{8'h32, 8'h50, 8'h5a, 8'h68, 8'h85};
    logic [7:0]  ops [12] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
                              8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};

    // system clock
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // design under test
    sdrlat_lookup dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_link_in(clk_link),
        .cmd_strobe_in(cmd_strobe), .cmd_opcode_in(cmd_opcode),
        .latency_code_in(latency_code_in), .band_133_in(band_133_in),
        .query_offset_in(query_offset_in), .query_byte_out(query_byte_out),
        .result_out(result_out));
    // far-side host
    sdrlat_host_model host (.clk_link_out(clk_link), .cmd_strobe_out(cmd_strobe),
        .cmd_opcode_out(cmd_opcode));

    // expected mode and latency per band and command class
    function automatic sdrlat_cyc_s exp_cyc(input logic [1:0] code, input logic b133,
                                            input int cls);
        if (code == 2'h3)
            return (cls == 4) ? 16'h0004 : (cls == 5) ? 16'h0201 : 16'h0000;
        if (cls == 0 || (b133 && cls != 1))
            return 16'hffff;
        if (cls == 4)
            return (code == 2'h0) ? 16'h0004 : (code == 2'h1) ? 16'h0005 : 16'h0006;
        if (cls == 5)
            return (code == 2'h2) ? 16'h0205 : 16'h0204;
        return 16'h0008;
    endfunction : exp_cyc

    // expected query parameter byte
    function automatic logic [7:0] exp_byte(input int o);
        int          r;
        int          k;
        sdrlat_cyc_s c;
        logic [7:0]  hdr [6] = '{8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43};
        if (o < 6)
            return hdr[o];
        if (o < 18)
            return ops[o - 6];
        if (o > 87)
            return 8'hff;
        r = (o - 18) / 14;
        k = (o - 18) % 14;
        c = exp_cyc(row_code[r], row_b133[r], (k - 2) / 2);
        return (k == 0) ? row_freq[r] : (k == 1) ? {6'h00, row_code[r]} : k[0] ? c.lat : c.mode;
    endfunction : exp_byte

    // byte compare
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_byte

    // answer compare
    task automatic chk_res(input string what, input sdrlat_res_s e, input sdrlat_res_s g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_res

    // reset with link edges inside, then check cleared state
    task automatic do_reset();
        rst_b_in = 1'b0;
        repeat (2) host.frame(1'b0, 8'h00);
        repeat (4) @(negedge clk_sys_in);
        chk_res("answer in reset", '{1'b0, 1'b0, CMD_NONE, 16'h0000}, result_out);
        chk_byte("query in reset", 8'h00, query_byte_out);
        rst_b_in = 1'b1;
        @(negedge clk_sys_in);
        chk_byte("query after reset", 8'h90, query_byte_out);
        $display("reset test done");
    endtask : do_reset

    // one command: send, wait for the answer pulse, compare
    task automatic run_cmd(input logic [7:0] op, input sdrlat_cmd_e cls, input sdrlat_cyc_s c);
        sdrlat_res_s e;
        int          n;
        e = '{1'b1, (c == 16'hffff), cls, c};
        host.frame(1'b1, op);
        n = 0;
        while (result_out.valid !== 1'b1 && n < 12)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        chk_res("answer", e, result_out);
        // keep strobes well apart
        repeat (4) @(negedge clk_sys_in);
    endtask : run_cmd

    // every read opcode in every band
    task automatic t_table();
        for (int r = 0; r < 5; r++)
        begin
            latency_code_in = row_code[r];
            band_133_in     = row_b133[r];
            @(negedge clk_sys_in);
            for (int i = 0; i < 12; i++)
                run_cmd(ops[i], sdrlat_cmd_e'(i / 2), exp_cyc(row_code[r], row_b133[r], i / 2));
        end
        run_cmd(8'h9f, CMD_NONE, 16'hffff);
        $display("table test done");
    endtask : t_table

    // walk the query parameter and past its end
    task automatic t_query();
        for (int o = 0; o < 96; o++)
        begin
            query_offset_in = o[6:0];
            @(negedge clk_sys_in);
            chk_byte("query byte", exp_byte(o), query_byte_out);
        end
        // id then row length on back-to-back cycles
        query_offset_in = 7'h00;
        @(negedge clk_sys_in);
        chk_byte("query id", 8'h90, query_byte_out);
        query_offset_in = 7'h03;
        @(negedge clk_sys_in);
        chk_byte("query row length", 8'h0e, query_byte_out);
        $display("query test done");
    endtask : t_query

    // verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // main sequence, mid-run reset after traffic
    initial
    begin
        rst_b_in        = 1'b0;
        latency_code_in = 2'h3;
        band_133_in     = 1'b0;
        query_offset_in = 7'h00;
        @(negedge clk_sys_in);
        do_reset();
        t_table();
        t_query();
        query_offset_in = 7'h00;
        do_reset();
        close_out();
    end

    // hang guard
    initial
    begin
        #50000;
        miscompares++;
        close_out();
    end
endmodule : sdrlat_lookup_tb
